// file: ddcns_dev.sv
// Our own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module ddcns_hb #(
  parameter int NTAP  = 7,
  parameter int BASE  = 0,
  parameter int SHIFT = 5
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              clr,
  // Input stream
  input  wire logic              inValid,
  input  wire logic signed [14:0] inI,
  input  wire logic signed [14:0] inQ,
  // Half-rate stream
  output logic                   outValid,
  output logic signed [14:0]     outI,
  output logic signed [14:0]     outQ
);
  localparam int HALF = (NTAP + 1) / 2;
  logic signed [14:0] dlyI_r [NTAP-1];
  logic signed [14:0] dlyQ_r [NTAP-1];
  logic signed [14:0] wI [NTAP];
  logic signed [14:0] wQ [NTAP];
  logic signed [47:0] accI;
  logic signed [47:0] accQ;
  logic               phase_r;
  logic               outValid_r;
  logic signed [14:0] outI_r;
  logic signed [14:0] outQ_r;

  function automatic logic signed [14:0] roundSat(
    input logic signed [47:0] a);
    logic signed [47:0] q;
    logic [47:0]        frac;
    logic [47:0]        half;
    q    = a >>> SHIFT;
    frac = a & ((48'h1 << SHIFT) - 48'h1);
    half = 48'h1 << (SHIFT - 1);
    if (frac > half || (frac == half && q[0]))
      q = q + 48'sh1;
    if (q > 48'sh3fff)
      return 15'h3fff;
    if (q < -48'sh4000)
      return 15'h4000;
    return q[14:0];
  endfunction

  assign wI[0] = inI;
  assign wQ[0] = inQ;
  for (genvar k = 0; k < NTAP - 1; k++) begin : g_dly
    assign wI[k+1] = dlyI_r[k];
    assign wQ[k+1] = dlyQ_r[k];
    always_ff @(posedge clk_sys) begin
      if (rst || clr) begin
        dlyI_r[k] <= '0;
        dlyQ_r[k] <= '0;
      end else if (inValid) begin
        dlyI_r[k] <= wI[k];
        dlyQ_r[k] <= wQ[k];
      end
    end
  end

  // Folded sum: mirrored taps share one multiply
  always_comb begin
    accI = '0;
    accQ = '0;
    for (int k = 0; k < HALF - 1; k++) begin
      accI = accI + 48'(ddcns_pkg::HB_COEF[BASE+k])
             * (48'(wI[k]) + 48'(wI[NTAP-1-k]));
      accQ = accQ + 48'(ddcns_pkg::HB_COEF[BASE+k])
             * (48'(wQ[k]) + 48'(wQ[NTAP-1-k]));
    end
    accI = accI + 48'(ddcns_pkg::HB_COEF[BASE+HALF-1]) * 48'(wI[HALF-1]);
    accQ = accQ + 48'(ddcns_pkg::HB_COEF[BASE+HALF-1]) * 48'(wQ[HALF-1]);
  end

  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      phase_r    <= 1'b0;
      outValid_r <= 1'b0;
      outI_r     <= '0;
      outQ_r     <= '0;
    end else begin
      outValid_r <= inValid && phase_r;
      if (inValid)
        phase_r <= ~phase_r;
      if (inValid && phase_r) begin
        outI_r <= roundSat(accI);
        outQ_r <= roundSat(accQ);
      end
    end
  end
  assign outValid = outValid_r;
  assign outI     = outI_r;
  assign outQ     = outQ_r;
endmodule

module ddcns_dev (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Configuration and link
  ddcns_if.dev                   link,
  // Converter and mixer samples
  input  wire logic              sampleValid,
  input  wire logic [11:0]       adcSample,
  input  wire logic signed [14:0] mixI,
  input  wire logic signed [14:0] mixQ,
  input  wire logic              overrangeFlagLow,
  input  wire logic              overrangeFlagHigh,
  // Oscillator phases to the mixer
  output logic [3:0][31:0]       oscPhase,
  // Link start-up status
  output logic                   codeGroupSync,
  output logic                   syncTriggerArmed
);
  logic [31:0]            freq_r [4];
  logic [15:0]            phase_r [4];
  logic [31:0]            acc_r [4];
  logic [3:0][31:0]       oscPhase_r;
  logic [15:0]            rdiv_r;
  logic                   syncIla_r;
  logic                   syncNext_r;
  logic                   linkEn_r;
  logic                   enc64_r;
  logic                   tsSel_r;
  ddcns_pkg::ddcns_dec_e  decSel_r;
  ddcns_pkg::ddcns_sync_e syncState_r;
  ddcns_pkg::ddcns_sync_e syncState_nxt;
  logic                   sysrefPrev_r;
  logic                   freqDirty_r;
  logic [31:0]            cfgRdata_r;
  logic [31:0]            rdMux;
  logic [ddcns_pkg::RDIV_CNT_W-1:0] rdivCnt_r;
  logic [ddcns_pkg::RDIV_CNT_W-1:0] rdivTop;
  logic [3:0]             wrFreq;
  logic [3:0]             wrPhase;
  logic [2:0]             startStage;
  logic [2:0]             decCode;
  logic signed [14:0]     cI [6];
  logic signed [14:0]     cQ [6];
  logic                   cV [6];
  logic                   outValid_r;
  logic [15:0]            outI_r;
  logic [15:0]            outQ_r;

  wire wrCtrl     = link.cfgWrite && link.cfgAddr == ddcns_pkg::REG_CTRL;
  wire wrRdiv     = link.cfgWrite && link.cfgAddr == ddcns_pkg::REG_RDIV;
  wire syncLevel  = tsSel_r ? link.timestampDiffInput
                            : link.singleEndedLinkSyncIn;
  wire sysrefRise = link.sysref && !sysrefPrev_r;
  wire ilaActive  = linkEn_r && syncIla_r;
  wire ilaSync    = ilaActive && syncState_r == ddcns_pkg::SYNC_ARMED
                    && syncLevel;
  wire nextSync   = syncNext_r && sysrefRise;
  wire oscSync    = ilaSync || nextSync;
  wire rdivWrap   = rdiv_r != 16'h0 && rdivCnt_r == rdivTop;
  assign rdivTop  = {rdiv_r, 6'h0} - 22'h1;
  assign decCode  = link.cfgWdata[ddcns_pkg::CTRL_DEC_LSB +: 3];

  // Link-init sync: arms on SYNC low, fires on the rising edge
  always_comb begin
    syncState_nxt = syncState_r;
    case (syncState_r)
      ddcns_pkg::SYNC_IDLE:
        if (ilaActive)
          syncState_nxt = ddcns_pkg::SYNC_WAIT_LOW;
      ddcns_pkg::SYNC_WAIT_LOW:
        if (!ilaActive)
          syncState_nxt = ddcns_pkg::SYNC_IDLE;
        else if (!syncLevel)
          syncState_nxt = ddcns_pkg::SYNC_ARMED;
      ddcns_pkg::SYNC_ARMED:
        if (!ilaActive)
          syncState_nxt = ddcns_pkg::SYNC_IDLE;
        else if (syncLevel)
          syncState_nxt = ddcns_pkg::SYNC_WAIT_LOW;
      default:
        syncState_nxt = ddcns_pkg::SYNC_IDLE;
    endcase
  end
  assign codeGroupSync    = syncState_r == ddcns_pkg::SYNC_ARMED
                            && !enc64_r;
  assign syncTriggerArmed = syncState_r == ddcns_pkg::SYNC_ARMED
                            && enc64_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncState_r  <= ddcns_pkg::SYNC_IDLE;
      sysrefPrev_r <= 1'b0;
    end else begin
      syncState_r  <= syncState_nxt;
      sysrefPrev_r <= link.sysref;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncIla_r  <= 1'b0;
      syncNext_r <= 1'b0;
      linkEn_r   <= 1'b0;
      enc64_r    <= 1'b0;
      tsSel_r    <= 1'b0;
      decSel_r   <= ddcns_pkg::DEC_BYPASS;
    end else if (wrCtrl) begin
      syncIla_r  <= link.cfgWdata[ddcns_pkg::CTRL_SYNC_ILA];
      syncNext_r <= link.cfgWdata[ddcns_pkg::CTRL_SYNC_NEXT];
      linkEn_r   <= link.cfgWdata[ddcns_pkg::CTRL_LINK_EN];
      enc64_r    <= link.cfgWdata[ddcns_pkg::CTRL_ENC64];
      tsSel_r    <= link.cfgWdata[ddcns_pkg::CTRL_TS_SEL];
      decSel_r   <= decCode > 3'h4 ? ddcns_pkg::DEC_BYPASS
                                   : ddcns_pkg::ddcns_dec_e'(decCode);
    end else if (nextSync) begin
      syncNext_r <= 1'b0;
    end
  end

  // Any 16-bit divider is taken; large values only cost spur level
  always_ff @(posedge clk_sys) begin
    if (rst)
      rdiv_r <= 16'h0;
    else if (wrRdiv)
      rdiv_r <= link.cfgWdata[15:0];
  end

  // Shared step counter pulls every accumulator back to exact zero
  always_ff @(posedge clk_sys) begin
    if (rst || oscSync || rdiv_r == 16'h0)
      rdivCnt_r <= '0;
    else if (sampleValid)
      rdivCnt_r <= rdivWrap ? '0 : rdivCnt_r + 22'h1;
  end

  for (genvar k = 0; k < 4; k++) begin : g_osc
    assign wrFreq[k]  = link.cfgWrite
                        && link.cfgAddr == ddcns_pkg::REG_FREQ0 + 4'(k);
    assign wrPhase[k] = link.cfgWrite
                        && link.cfgAddr == ddcns_pkg::REG_PHASE0 + 4'(k);
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        freq_r[k]  <= '0;
        phase_r[k] <= '0;
      end else begin
        if (wrFreq[k])
          freq_r[k] <= link.cfgWdata;
        if (wrPhase[k])
          phase_r[k] <= link.cfgWdata[15:0];
      end
    end
    // Runs whether or not this oscillator feeds the mixer
    always_ff @(posedge clk_sys) begin
      if (rst || oscSync)
        acc_r[k] <= '0;
      else if (sampleValid)
        acc_r[k] <= rdivWrap ? '0 : acc_r[k] + freq_r[k];
    end
    always_ff @(posedge clk_sys) begin
      if (rst)
        oscPhase_r[k] <= '0;
      else
        oscPhase_r[k] <= acc_r[k]
          + {phase_r[k], 16'h0};
    end
  end
  assign oscPhase = oscPhase_r;

  // Set by a frequency write, cleared by a sync; a write wins
  always_ff @(posedge clk_sys) begin
    if (rst)
      freqDirty_r <= 1'b0;
    else if (|wrFreq)
      freqDirty_r <= 1'b1;
    else if (oscSync)
      freqDirty_r <= 1'b0;
  end

  always_comb begin
    rdMux = 32'h0;
    if (link.cfgAddr < ddcns_pkg::REG_PHASE0)
      rdMux = freq_r[link.cfgAddr[1:0]];
    else if (link.cfgAddr < ddcns_pkg::REG_RDIV)
      rdMux = {16'h0, phase_r[link.cfgAddr[1:0]]};
    else if (link.cfgAddr == ddcns_pkg::REG_RDIV)
      rdMux = {16'h0, rdiv_r};
    else if (link.cfgAddr == ddcns_pkg::REG_CTRL)
      rdMux = {24'h0, decSel_r, tsSel_r, enc64_r, linkEn_r,
               syncNext_r, syncIla_r};
    else if (link.cfgAddr == ddcns_pkg::REG_STAT)
      rdMux = {28'h0, syncTriggerArmed, codeGroupSync,
               syncNext_r, freqDirty_r};
  end
  always_ff @(posedge clk_sys) begin
    if (rst)
      cfgRdata_r <= '0;
    else if (link.cfgRead)
      cfgRdata_r <= rdMux;
  end
  assign link.cfgRdata = cfgRdata_r;

  // Decimation chain; entry stage set by the factor
  assign startStage = 3'(ddcns_pkg::NSTAGE - 1) - decSel_r;
  assign cI[0] = mixI;
  assign cQ[0] = mixQ;
  assign cV[0] = sampleValid;
  for (genvar s = 0; s < ddcns_pkg::NSTAGE; s++) begin : g_hb
    wire stV = decSel_r != ddcns_pkg::DEC_BYPASS
               && (3'(s) == startStage ? sampleValid
                   : 3'(s) > startStage && cV[s]);
    wire signed [14:0] stI = 3'(s) == startStage ? mixI : cI[s];
    wire signed [14:0] stQ = 3'(s) == startStage ? mixQ : cQ[s];
    ddcns_hb #(
      .NTAP  (ddcns_pkg::HB_NTAP[s]),
      .BASE  (ddcns_pkg::HB_BASE[s]),
      .SHIFT (ddcns_pkg::HB_SHIFT[s])
    ) u_hb (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .clr      (wrCtrl),
      .inValid  (stV),
      .inI      (stI),
      .inQ      (stQ),
      .outValid (cV[s+1]),
      .outI     (cI[s+1]),
      .outQ     (cQ[s+1])
    );
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      outValid_r <= 1'b0;
      outI_r     <= '0;
      outQ_r     <= '0;
    end else if (decSel_r == ddcns_pkg::DEC_BYPASS) begin
      outValid_r <= sampleValid;
      if (sampleValid) begin
        outI_r <= {adcSample, 4'h0};
        outQ_r <= '0;
      end
    end else begin
      outValid_r <= cV[ddcns_pkg::NSTAGE];
      if (cV[ddcns_pkg::NSTAGE]) begin
        outI_r <= {cI[ddcns_pkg::NSTAGE], overrangeFlagLow};
        outQ_r <= {cQ[ddcns_pkg::NSTAGE], overrangeFlagHigh};
      end
    end
  end
  assign link.outValid = outValid_r;
  assign link.outI     = outI_r;
  assign link.outQ     = outQ_r;
endmodule

// file: ddcns_pkg.sv
package ddcns_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DW            = 15;
  localparam int AW            = 48;
  // Device register index on the configuration port
  localparam logic [3:0] REG_FREQ0  = 4'h0;
  localparam logic [3:0] REG_PHASE0 = 4'h4;
  localparam logic [3:0] REG_RDIV   = 4'h8;
  localparam logic [3:0] REG_CTRL   = 4'h9;
  localparam logic [3:0] REG_STAT   = 4'ha;
  // Control register fields
  localparam int CTRL_SYNC_ILA  = 0;
  localparam int CTRL_SYNC_NEXT = 1;
  localparam int CTRL_LINK_EN   = 2;
  localparam int CTRL_ENC64     = 3;
  localparam int CTRL_TS_SEL    = 4;
  localparam int CTRL_DEC_LSB   = 5;
  // Status register fields
  localparam int STAT_DIRTY = 0;
  localparam int STAT_NEXT  = 1;
  localparam int STAT_CGS   = 2;
  localparam int STAT_ARMED = 3;
  // Oscillator
  localparam int RDIV_STEP_MUL = 64;
  localparam int RDIV_CNT_W    = 22;
  localparam int PHASE_SHIFT   = 16;
  // Half-band stages, first to fifth
  localparam int NSTAGE          = 5;
  localparam int HB_NTAP [0:4]   = '{7, 7, 11, 15, 55};
  localparam int HB_BASE [0:4]   = '{0, 4, 8, 14, 22};
  localparam int HB_SHIFT [0:4]  = '{5, 11, 14, 17, 19};
  localparam int HB_COEF [0:49]  = '{
    -1, 0, 9, 16,
    -65, 0, 577, 1024,
    109, 0, -837, 0, 4824, 8192,
    -327, 0, 2231, 0, -8881, 0, 39742, 65536,
    -37, 0, 118, 0, -291, 0, 612, 0, -1159, 0, 2031, 0, -3356, 0,
    5308, 0, -8140, 0, 12284, 0, -18628, 0, 29455, 0, -53191, 0,
    166059, 262144};
  typedef enum logic [2:0] {DEC_BYPASS, DEC_4, DEC_8, DEC_16, DEC_32}
    ddcns_dec_e;
  typedef enum logic [1:0] {SYNC_IDLE, SYNC_WAIT_LOW, SYNC_ARMED}
    ddcns_sync_e;
  // Host Avalon byte offsets
  localparam logic [4:0] HOST_DEV_ADDR  = 5'h00;
  localparam logic [4:0] HOST_DEV_WDATA = 5'h04;
  localparam logic [4:0] HOST_DEV_RDATA = 5'h08;
  localparam logic [4:0] HOST_LINK      = 5'h0c;
  localparam logic [4:0] HOST_SAMPLE    = 5'h10;
  localparam int LINK_SYNC         = 0;
  localparam int LINK_SYSREF_PULSE = 1;
  localparam int LINK_SYSREF_RUN   = 2;
  localparam int SYSREF_PERIOD_NS  = 1280;
  localparam int SYSREF_PERIOD_CYC = SYSREF_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// file: ddcns_if.sv
`timescale 1ns/10ps
interface ddcns_if (input wire logic clk_sys);
  logic        cfgWrite;
  logic        cfgRead;
  logic [3:0]  cfgAddr;
  logic [31:0] cfgWdata;
  logic [31:0] cfgRdata;
  logic        singleEndedLinkSyncIn;
  logic        timestampDiffInput;
  logic        sysref;
  logic        outValid;
  logic [15:0] outI;
  logic [15:0] outQ;
  modport dev (input cfgWrite, cfgRead, cfgAddr, cfgWdata,
               singleEndedLinkSyncIn, timestampDiffInput, sysref,
               output cfgRdata, outValid, outI, outQ);
  modport host (output cfgWrite, cfgRead, cfgAddr, cfgWdata,
                singleEndedLinkSyncIn, timestampDiffInput, sysref,
                input cfgRdata, outValid, outI, outQ);
endinterface

// file: ddcns_host.sv
`timescale 1ns/10ps
module ddcns_host (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  output logic [31:0]      avsReaddata,
  output logic             avsWaitrequest,
  // Device link
  ddcns_if.host            link
);
  logic [1:0]  cnt_r;
  logic [3:0]  devAddr_r;
  logic [31:0] devWdata_r;
  logic        cfgWrite_r;
  logic        cfgRead_r;
  logic        syncLevel_r;
  logic        sysrefRun_r;
  logic        sysref_r;
  logic [31:0] sample_r;
  logic [15:0] perCnt_r;

  wire hitAddr  = avsAddress == ddcns_pkg::HOST_DEV_ADDR;
  wire hitWdata = avsAddress == ddcns_pkg::HOST_DEV_WDATA;
  wire hitRdata = avsAddress == ddcns_pkg::HOST_DEV_RDATA;
  wire hitLink  = avsAddress == ddcns_pkg::HOST_LINK;
  wire hitSamp  = avsAddress == ddcns_pkg::HOST_SAMPLE;
  wire req      = avsRead || avsWrite;
  wire [1:0] need = avsRead && hitRdata ? 2'h2 : 2'h1;
  wire done     = req && cnt_r == need;
  wire wrDone   = avsWrite && done;
  wire perWrap  = perCnt_r == 16'(ddcns_pkg::SYSREF_PERIOD_CYC - 1);

  assign avsWaitrequest = req && !done;

  always_comb begin
    avsReaddata = 32'h0;
    if (hitAddr)
      avsReaddata = {28'h0, devAddr_r};
    else if (hitWdata)
      avsReaddata = devWdata_r;
    else if (hitRdata)
      avsReaddata = link.cfgRdata;
    else if (hitLink)
      avsReaddata = {29'h0, sysrefRun_r, 1'b0, syncLevel_r};
    else if (hitSamp)
      avsReaddata = sample_r;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      cnt_r <= 2'h0;
    else
      cnt_r <= (req && !done) ? cnt_r + 2'h1 : 2'h0;
  end

  // Device accesses are issued one word at a time, in program order
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      devAddr_r  <= 4'h0;
      devWdata_r <= 32'h0;
      cfgWrite_r <= 1'b0;
      cfgRead_r  <= 1'b0;
    end else begin
      cfgWrite_r <= wrDone && hitWdata;
      cfgRead_r  <= avsRead && hitRdata && cnt_r == 2'h0;
      if (wrDone && hitAddr)
        devAddr_r <= avsWritedata[3:0];
      if (wrDone && hitWdata)
        devWdata_r <= avsWritedata;
    end
  end

  // Receiver side: SYNC level and SYSREF source
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      syncLevel_r <= 1'b1;
      sysrefRun_r <= 1'b0;
    end else if (wrDone && hitLink) begin
      syncLevel_r <= avsWritedata[ddcns_pkg::LINK_SYNC];
      sysrefRun_r <= avsWritedata[ddcns_pkg::LINK_SYSREF_RUN];
    end
  end

  // A long fixed period leaves room to time the arming write
  always_ff @(posedge clk_sys) begin
    if (rst || !sysrefRun_r)
      perCnt_r <= 16'h0;
    else
      perCnt_r <= perWrap ? 16'h0 : perCnt_r + 16'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      sysref_r <= 1'b0;
    else
      sysref_r <= (wrDone && hitLink
                   && avsWritedata[ddcns_pkg::LINK_SYSREF_PULSE])
                  || (sysrefRun_r && perWrap);
  end

  always_ff @(posedge clk_sys) begin
    if (rst)
      sample_r <= 32'h0;
    else if (link.outValid)
      sample_r <= {link.outQ, link.outI};
  end

  assign link.cfgWrite              = cfgWrite_r;
  assign link.cfgRead               = cfgRead_r;
  assign link.cfgAddr               = devAddr_r;
  assign link.cfgWdata              = devWdata_r;
  assign link.singleEndedLinkSyncIn = syncLevel_r;
  assign link.timestampDiffInput    = syncLevel_r;
  assign link.sysref                = sysref_r;
endmodule

// file: ddcns_chk.sv
`timescale 1ns/10ps
module ddcns_chk (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Configuration port
  input wire logic        cfgWrite,
  input wire logic        cfgRead,
  input wire logic [3:0]  cfgAddr,
  input wire logic [31:0] cfgWdata,
  input wire logic [31:0] cfgRdata,
  // Link and stream
  input wire logic        sysref,
  input wire logic        outValid,
  input wire logic [15:0] outI,
  input wire logic [15:0] outQ
);
  logic [7:0] ctrlR;
  logic       armR;
  logic       srPrevR;
  logic [6:0] gapR;
  logic [1:0] ageR;
  wire        ctrlWr = cfgWrite && cfgAddr == ddcns_pkg::REG_CTRL;
  wire  [2:0] dec = ctrlR[7:5];
  wire  [6:0] need = 7'h2 << dec;
  wire        settled = ageR == 2'h3;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys)
    ctrlR <= rst ? 8'h0 : ctrlWr ? cfgWdata[7:0] : ctrlR;
  always_ff @(posedge clk_sys)
    srPrevR <= !rst && sysref;
  // Software write wins over the self clear in the same cycle
  always_ff @(posedge clk_sys)
    armR <= rst ? 1'b0 : ctrlWr ? cfgWdata[1] :
            (sysref && !srPrevR) ? 1'b0 : armR;
  // A filter flush restarts the spacing count like an output does
  always_ff @(posedge clk_sys)
    gapR <= (rst || outValid || ctrlWr) ? 7'h1 : gapR + {6'h0, gapR != 7'h7f};
  always_ff @(posedge clk_sys)
    ageR <= (rst || ctrlWr) ? 2'h0 : ageR + {1'b0, ageR != 2'h3};
  property p_bypassQ;
    outValid && dec == 3'h0 && settled |-> outQ == 16'h0;
  endproperty
  a_bypassQ: assert property (p_bypassQ) else $error("bypass Q not 0");
  property p_bypassPad;
    outValid && dec == 3'h0 && settled |-> outI[3:0] == 4'h0;
  endproperty
  a_bypassPad: assert property (p_bypassPad) else $error("bypass pad");
  property p_decGap;
    outValid && dec != 3'h0 && settled |-> gapR >= need;
  endproperty
  a_decGap: assert property (p_decGap) else $error("output too soon");
  property p_phaseWidth;
    cfgRead && cfgAddr[3:2] == 2'b01 |=> cfgRdata[31:16] == 16'h0;
  endproperty
  a_phaseWidth: assert property (p_phaseWidth) else $error("phase wide");
  property p_rdivWidth;
    cfgRead && cfgAddr == ddcns_pkg::REG_RDIV |=> cfgRdata[31:16] == 16'h0;
  endproperty
  a_rdivWidth: assert property (p_rdivWidth) else $error("divider wide");
  property p_armClear;
    cfgRead && cfgAddr == ddcns_pkg::REG_STAT
      |=> cfgRdata[ddcns_pkg::STAT_NEXT] == $past(armR);
  endproperty
  a_armClear: assert property (p_armClear) else $error("arm bit wrong");
  property p_sysrefPulse;
    sysref |=> !sysref;
  endproperty
  a_sysrefPulse: assert property (p_sysrefPulse) else $error("long pulse");
  property p_ctrlEcho;
    cfgRead && cfgAddr == ddcns_pkg::REG_CTRL |=> cfgRdata[31:8] == 24'h0
      && cfgRdata[7:2] == $past(ctrlR[7:2]) && cfgRdata[0] == $past(ctrlR[0]);
  endproperty
  a_ctrlEcho: assert property (p_ctrlEcho) else $error("control echo");
endmodule

// file: ddcns_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); \
  end \
end
module ddcns_bench;
  logic               clk_sys, rst, avsRead, avsWrite, avsWaitrequest, hit;
  logic [4:0]         avsAddress;
  logic [31:0]        avsWritedata, avsReaddata, rd, lfsr, f, p;
  logic               sampleValid, overrangeFlagLow, overrangeFlagHigh;
  logic [11:0]        adcSample;
  logic [1:0][11:0]   h;
  logic signed [14:0] mixI, mixQ;
  logic [3:0][31:0]   oscPhase;
  logic               codeGroupSync, syncTriggerArmed;
  logic [15:0]        lastI, lastQ;
  int                 fails, checked, cnt, xi, xq, ne;
  ddcns_if i_ddcns_if (.clk_sys(clk_sys));
  wire [32:0] outW = {i_ddcns_if.outValid, i_ddcns_if.outQ, i_ddcns_if.outI};
  ddcns_dev i_ddcns_dev (.clk_sys, .rst, .link(i_ddcns_if.dev), .sampleValid,
    .adcSample, .mixI, .mixQ, .overrangeFlagLow, .overrangeFlagHigh,
    .oscPhase, .codeGroupSync, .syncTriggerArmed);
  ddcns_host i_ddcns_host (.clk_sys, .rst, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsReaddata, .avsWaitrequest, .link(i_ddcns_if.host));
  ddcns_chk i_ddcns_chk (.clk_sys, .rst, .cfgWrite(i_ddcns_if.cfgWrite),
    .cfgRead(i_ddcns_if.cfgRead), .cfgAddr(i_ddcns_if.cfgAddr),
    .cfgWdata(i_ddcns_if.cfgWdata), .cfgRdata(i_ddcns_if.cfgRdata),
    .sysref(i_ddcns_if.sysref), .outValid(i_ddcns_if.outValid),
    .outI(i_ddcns_if.outI), .outQ(i_ddcns_if.outQ));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // DC through the used stages; rounding only at each stage output
  function automatic logic [14:0] expDc(input int x, input int d);
    longint y, s, q, r, hh;
    int     sh, nt;
    y = x;
    for (int k = 4 - d; k < 5; k++) begin
      s = 0;
      sh = ddcns_pkg::HB_SHIFT[k];
      nt = ddcns_pkg::HB_NTAP[k] / 2;
      for (int t = 0; t <= nt; t++) begin
        q = ddcns_pkg::HB_COEF[ddcns_pkg::HB_BASE[k] + t] * y;
        s += (t == nt) ? q : 2 * q;
      end
      q = s >>> sh;
      r = s - (q <<< sh);
      hh = 1 <<< (sh - 1);
      if (r > hh || (r == hh && q[0])) q++;
      y = q;
    end
    return y[14:0];
  endfunction
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 40);
    rd = avsReaddata;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (avsWaitrequest !== 1'b0) begin
      $display("MISMATCH waitrequest exp 0 got %b", avsWaitrequest);
      fails++;
      print_verdict();
    end
    @(posedge clk_sys);
  endtask
  task automatic dw(input logic [3:0] i, input logic [31:0] d);
    av(1'b1, ddcns_pkg::HOST_DEV_ADDR, {28'h0, i});
    av(1'b1, ddcns_pkg::HOST_DEV_WDATA, d);
  endtask
  task automatic dr(input logic [3:0] i);
    av(1'b1, ddcns_pkg::HOST_DEV_ADDR, {28'h0, i});
    av(1'b0, ddcns_pkg::HOST_DEV_RDATA, 32'h0);
  endtask
  task automatic seeSync(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge clk_sys);
      if (oscPhase[0] === 32'h12340000) hit = 1'b1;
    end
  endtask
  task print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {rst, avsAddress, avsRead, avsWrite, avsWritedata} = {1'b1, 39'h0};
    {sampleValid, adcSample, mixI, mixQ} = {1'b1, 42'h0};
    {overrangeFlagLow, overrangeFlagHigh, h} = 26'h0;
    {fails, checked, lfsr} = {64'h0, 32'h93a45203};
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    dr(ddcns_pkg::REG_CTRL);
    `CHK("ctrl reset", 32'h0, rd)
    av(1'b0, 5'h14, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    lfsr = nx(lfsr);
    f = lfsr;
    dw(ddcns_pkg::REG_FREQ0, f);
    dw(ddcns_pkg::REG_PHASE0, 32'habcd1234);
    for (int k = 1; k < 4; k++)
      dw(ddcns_pkg::REG_PHASE0 + 4'(k), 32'(k) << 14);
    dr(ddcns_pkg::REG_PHASE0);
    `CHK("phase", 32'h1234, rd)
    for (int k = 1; k < 4; k++)
      `CHK("osc", 32'(k) << 30, oscPhase[k])
    dw(ddcns_pkg::REG_CTRL, 32'h6);
    dr(ddcns_pkg::REG_STAT);
    `CHK("armed", 2'h3, rd[1:0])
    av(1'b1, ddcns_pkg::HOST_LINK, 32'h3);
    seeSync(12);
    `CHK("sysref sync", 1'b1, hit)
    dr(ddcns_pkg::REG_STAT);
    `CHK("disarmed", 2'h0, rd[1:0])
    p = oscPhase[0];
    @(posedge clk_sys);
    `CHK("step", p + f, oscPhase[0])
    dw(ddcns_pkg::REG_RDIV, 32'h55550001);
    dr(ddcns_pkg::REG_RDIV);
    `CHK("rdiv", 32'h1, rd)
    // The first wrap zeroes whatever the accumulator held before
    repeat (64) @(posedge clk_sys);
    p = oscPhase[0];
    repeat (64) @(posedge clk_sys);
    `CHK("wrap", p, oscPhase[0])
    dw(ddcns_pkg::REG_RDIV, 32'h0);
    for (int e = 0; e < 2; e++) begin
      dw(ddcns_pkg::REG_CTRL, e ? 32'h19 : 32'h1);
      dw(ddcns_pkg::REG_FREQ0, f);
      av(1'b1, ddcns_pkg::HOST_LINK, 32'h1);
      dw(ddcns_pkg::REG_CTRL, e ? 32'h1d : 32'h5);
      av(1'b1, ddcns_pkg::HOST_LINK, 32'h0);
      repeat (4) @(posedge clk_sys);
      `CHK("link arm", e ? 2'h1 : 2'h2, {codeGroupSync, syncTriggerArmed})
      av(1'b1, ddcns_pkg::HOST_LINK, 32'h1);
      seeSync(12);
      `CHK("sync edge", 1'b1, hit)
    end
    av(1'b1, ddcns_pkg::HOST_LINK, 32'h5);
    dw(ddcns_pkg::REG_CTRL, 32'h6);
    seeSync(140);
    `CHK("running sysref", 1'b1, hit)
    av(1'b1, ddcns_pkg::HOST_LINK, 32'h1);
    dw(ddcns_pkg::REG_CTRL, 32'h0);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (i > 1) `CHK("bypass", {1'b1, 16'h0, h[1], 4'h0}, outW)
      h[1] = h[0];
      lfsr = nx(lfsr);
      h[0] = lfsr[11:0];
      adcSample <= h[0];
    end
    for (int d = 1; d < 5; d++) begin
      lfsr = nx(lfsr);
      xi = $signed(lfsr[11:0]);
      xq = $signed(lfsr[27:16]);
      mixI <= xi[14:0];
      mixQ <= xq[14:0];
      overrangeFlagLow <= lfsr[12];
      overrangeFlagHigh <= lfsr[13];
      dw(ddcns_pkg::REG_CTRL, 32'(d) << 5);
      cnt = 0;
      ne = 2000 / (2 << d);
      repeat (2000) begin
        @(posedge clk_sys);
        if (i_ddcns_if.outValid === 1'b1) begin
          cnt++;
          {lastI, lastQ} = {i_ddcns_if.outI, i_ddcns_if.outQ};
        end
      end
      `CHK("rate", 1'b1, cnt >= ne - 3 && cnt <= ne + 1)
      `CHK("dc I", {expDc(xi, d), lfsr[12]}, lastI)
      `CHK("dc Q", {expDc(xq, d), lfsr[13]}, lastQ)
      av(1'b0, ddcns_pkg::HOST_SAMPLE, 32'h0);
      `CHK("sample", {expDc(xq, d), lfsr[13], expDc(xi, d), lfsr[12]}, rd)
    end
    print_verdict();
  end
endmodule
